// ===== core/rtc_top.sv
// Real-time clock: oscillator pick, tick chain, time counter, alarm, wake.
// Assumes control inputs come from logic on CLK_SYS; oscillator pins do not.
//
// How it works
// RL1 - Clock taken straight from either oscillator
// RL2 - Keeps counting in idle and power-down
// RL3 - Cyclic interrupt every tick and n ticks
// RL4 - Chained counters form one 58-bit timer
// RL5 - Wake config set: leave power-down after delay
// RL6 - Input divided by 64, then 20-bit divider
// RL7 - Divider reloads tick period each tick
// RL8 - Tick interrupt once per basic tick
// RL9 - Loadable 32-bit time counter counts ticks
// RL10 - Time continuously compared with 32-bit alarm
// RL11 - Equal time and alarm raises alarm interrupt
// RL12 - Interrupts routable to fast wake interrupt
// RL13 - Oscillator-off bit stops clock in power-down
// RL14 - Disabled: both oscillators off in power-down
// RL15 - Low-power oscillation detected: use it
// RL16 - Low-power source: main off in power-down
// RL17 - No low-power oscillation: use main oscillator
// RL18 - Main source, enabled: main stays on
// RL19 - Timekeeper state reachable by software side
// RL20 - Time counter wraps to zero
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"

module rtc_top #(
  parameter int unsigned DETECT_CYCLES = (`RTC_DETECT_WINDOW_NS * 1000) / `RTC_CLK_PERIOD_PS
) (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic MAIN_OSC_INPUT,
  input wire logic LOW_POWER_OSC_INPUT,
  input wire logic TIMEKEEPER_ENABLE,
  input wire logic OSC_OFF_IN_POWERDOWN,
  input wire logic POWERDOWN_WAKE_CONFIG,
  input wire logic IDLE_MODE,
  input wire logic POWERDOWN_MODE,
  input wire logic [`RTC_DIV_W-1:0] TICK_PERIOD_RELOAD,
  input wire logic TIME_LOAD,
  input wire logic [`RTC_TIME_W-1:0] TIME_LOAD_VALUE,
  input wire logic ALARM_LOAD,
  input wire logic [`RTC_TIME_W-1:0] ALARM_LOAD_VALUE,
  input wire logic TICK_N_ENABLE,
  input wire logic [`RTC_TICKN_W-1:0] TICK_N_COUNT,
  input wire logic ALARM_ENABLE,
  input wire logic [1:0] EXTERNAL_IRQ_SOURCE_SELECT,
  output logic TICK_INTERRUPT,
  output logic TICK_N_INTERRUPT,
  output logic ALARM_INTERRUPT,
  output logic FAST_EXT_IRQ,
  output logic POWERDOWN_WAKE,
  output logic MAIN_OSC_ENABLE,
  output logic LOW_POWER_OSC_OUTPUT,
  output logic LP_OSC_SELECTED,
  output logic DETECT_DONE,
  output logic [`RTC_TIME_W-1:0] TIME_COUNT,
  output logic [`RTC_TIME_W-1:0] ALARM_VALUE,
  output logic [`RTC_LONG_W-1:0] LONG_TIMER
);

  rtc_pre_if pre_if ();

  logic [1:0] pin_in;
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] pin_prev;
  logic [1:0] pin_edge;
  rtc_pkg::rtc_state_t state;
  rtc_pkg::rtc_src_t src;
  logic [31:0] win_count;
  logic [7:0] lp_edges;
  logic keep_running;
  logic alarm_match;
  logic alarm_match_q;
  logic [`RTC_TICKN_W-1:0] tick_n_count;
  logic next_fast;

  // ==========================================================
  // Oscillator pin synchronisers
  // Both pins come from free oscillators, so each gets two flops first
  assign pin_in = {LOW_POWER_OSC_INPUT, MAIN_OSC_INPUT};

  generate
    for (genvar i = 0; i < 2; i++) begin : g_sync
      // Two-flop synchroniser, then an edge detector on the second stage
      always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
          sync1[i] <= 1'b0;
          sync2[i] <= 1'b0;
          pin_prev[i] <= 1'b0;
        end else begin
          sync1[i] <= pin_in[i];
          sync2[i] <= sync1[i];
          pin_prev[i] <= sync2[i];
        end
      end
      assign pin_edge[i] = sync2[i] && !pin_prev[i];
    end
  endgenerate

  // ==========================================================
  // Start-up detection of the low-power oscillator
  // The window restarts on every reset, so detection happens at power-on
  // and after each reset alike; a dead crystal simply yields no edges.
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state <= rtc_pkg::RTC_ST_DETECT;
      win_count <= 32'h00000000;
    end else begin
      unique case (state)
        rtc_pkg::RTC_ST_DETECT: begin
          win_count <= win_count + 32'h00000001;
          if (win_count >= DETECT_CYCLES - 1) begin
            state <= rtc_pkg::RTC_ST_DECIDE;
          end
        end
        rtc_pkg::RTC_ST_DECIDE: begin
          state <= rtc_pkg::RTC_ST_RUN;
        end
        rtc_pkg::RTC_ST_RUN: begin
          state <= rtc_pkg::RTC_ST_RUN;
        end
      endcase
    end
  end

  // Edge count saturates so a long window cannot wrap it back below threshold
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      lp_edges <= 8'h00;
    end else if (state == rtc_pkg::RTC_ST_DETECT && pin_edge[1] && lp_edges != 8'hFF) begin
      lp_edges <= lp_edges + 8'h01;
    end
  end

  // RL15 pick low-power source
  // RL17 else main oscillator
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      src <= rtc_pkg::RTC_SRC_MAIN;
    end else if (state == rtc_pkg::RTC_ST_DECIDE) begin
      src <= (lp_edges >= `RTC_DETECT_EDGES) ? rtc_pkg::RTC_SRC_LP : rtc_pkg::RTC_SRC_MAIN;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      LP_OSC_SELECTED <= 1'b0;
      DETECT_DONE <= 1'b0;
    end else begin
      LP_OSC_SELECTED <= (src == rtc_pkg::RTC_SRC_LP);
      DETECT_DONE <= (state == rtc_pkg::RTC_ST_RUN);
    end
  end

  // ==========================================================
  // Feed of the prescaler
  // The timekeeper keeps its oscillator only when enabled and not told
  // to drop it in power-down.
  assign keep_running = TIMEKEEPER_ENABLE && !(POWERDOWN_MODE && OSC_OFF_IN_POWERDOWN);

  // RL1 direct oscillator edge
  assign pre_if.osc_edge = (src == rtc_pkg::RTC_SRC_LP) ? pin_edge[1] : pin_edge[0];
  // RL2 idle does not gate
  // IDLE_MODE is deliberately not a term: counting goes on in idle
  assign pre_if.run = keep_running && (state == rtc_pkg::RTC_ST_RUN);
  assign pre_if.period = TICK_PERIOD_RELOAD;

  rtc_prescaler u_pre (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .pre_if(pre_if)
  );

  // ==========================================================
  // Time counter
  // RL9 load and count
  // RL19 software load port
  // A load in the tick cycle wins: software sets the time it means to set
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      TIME_COUNT <= `RTC_TIME_RST;
    end else if (TIME_LOAD) begin
      TIME_COUNT <= TIME_LOAD_VALUE;
    end else if (pre_if.tick) begin
      // RL20 wrap past all-ones
      TIME_COUNT <= TIME_COUNT + 32'h00000001;
    end
  end

  // Alarm register
  // RL19 software alarm load
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ALARM_VALUE <= `RTC_ALARM_RST;
    end else if (ALARM_LOAD) begin
      ALARM_VALUE <= ALARM_LOAD_VALUE;
    end
  end

  // RL4 58-bit chain view
  // The 20-bit divider stage counts down while the divide-by-64 stage counts up, so this is a raw chain image
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      LONG_TIMER <= '0;
    end else begin
      LONG_TIMER <= {TIME_COUNT, pre_if.div_count, pre_if.pre_count};
    end
  end

  // ==========================================================
  // Interrupt requests
  // RL10 continuous compare
  assign alarm_match = (TIME_COUNT == ALARM_VALUE);

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      alarm_match_q <= 1'b1;
    end else begin
      alarm_match_q <= alarm_match;
    end
  end

  // RL11 alarm on match
  // Only the start of a match fires, so a held match gives one request
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      ALARM_INTERRUPT <= 1'b0;
    end else begin
      ALARM_INTERRUPT <= ALARM_ENABLE && alarm_match && !alarm_match_q;
    end
  end

  // RL8 tick request
  // RL3 every basic tick
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      TICK_INTERRUPT <= 1'b0;
    end else begin
      TICK_INTERRUPT <= pre_if.tick;
    end
  end

  // RL3 every n ticks
  // n of zero never fires; disabling also restarts the count
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      tick_n_count <= `RTC_TICKN_RST;
      TICK_N_INTERRUPT <= 1'b0;
    end else if (!TICK_N_ENABLE || TICK_N_COUNT == `RTC_TICKN_RST) begin
      tick_n_count <= `RTC_TICKN_RST;
      TICK_N_INTERRUPT <= 1'b0;
    end else if (pre_if.tick) begin
      if (tick_n_count >= TICK_N_COUNT - 16'h0001) begin
        tick_n_count <= `RTC_TICKN_RST;
        TICK_N_INTERRUPT <= 1'b1;
      end else begin
        tick_n_count <= tick_n_count + 16'h0001;
        TICK_N_INTERRUPT <= 1'b0;
      end
    end else begin
      TICK_N_INTERRUPT <= 1'b0;
    end
  end

  // ==========================================================
  // Fast external interrupt and wake
  // RL12 source select routing
  // The n-tick request shares the tick route; it is the programmed delay
  assign next_fast = (EXTERNAL_IRQ_SOURCE_SELECT[`RTC_SEL_TICK]
                      && (TICK_INTERRUPT || TICK_N_INTERRUPT))
                     || (EXTERNAL_IRQ_SOURCE_SELECT[`RTC_SEL_ALARM] && ALARM_INTERRUPT);

  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      FAST_EXT_IRQ <= 1'b0;
    end else begin
      FAST_EXT_IRQ <= next_fast;
    end
  end

  // RL5 wake from power-down
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      POWERDOWN_WAKE <= 1'b0;
    end else begin
      POWERDOWN_WAKE <= POWERDOWN_MODE && POWERDOWN_WAKE_CONFIG && next_fast;
    end
  end

  // ==========================================================
  // Oscillator enables
  // Outside power-down both run, so the detector can see the crystal.
  // Note: with the main source the clock survives power-down unless disabled or the oscillator-off bit is set.
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      MAIN_OSC_ENABLE <= 1'b1;
      LOW_POWER_OSC_OUTPUT <= 1'b1;
    end else if (!POWERDOWN_MODE) begin
      MAIN_OSC_ENABLE <= 1'b1;
      LOW_POWER_OSC_OUTPUT <= 1'b1;
    end else begin
      // RL16 low-power: main off
      // RL18 main kept if enabled
      // RL13 oscillator-off bit
      // RL14 disabled: both off
      MAIN_OSC_ENABLE <= (src == rtc_pkg::RTC_SRC_MAIN) && keep_running;
      LOW_POWER_OSC_OUTPUT <= (src == rtc_pkg::RTC_SRC_LP) && keep_running;
    end
  end

endmodule : rtc_top

`default_nettype wire

// ===== pkg/rtc_consts.svh
// Constants of the real-time clock block: widths, reset values, timing.
// Assumes it is included by bare name from the block's package and modules.
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

// ==========================================================
// Widths of the counter chain
`define RTC_PRE_W 6
`define RTC_DIV_W 20
`define RTC_TIME_W 32
`define RTC_LONG_W 58
`define RTC_TICKN_W 16

// ==========================================================
// Fixed prescale and reset values
`define RTC_PRE_LAST 6'h3F
`define RTC_DIV_RST 20'h00000
`define RTC_TIME_RST 32'h00000000
`define RTC_ALARM_RST 32'hFFFFFFFF
`define RTC_TICKN_RST 16'h0000

// ==========================================================
// Oscillator detection after reset
`define RTC_CLK_PERIOD_PS 4000
`define RTC_DETECT_WINDOW_NS 100000
`define RTC_DETECT_EDGES 8'h04

// ==========================================================
// External interrupt source select bits
`define RTC_SEL_TICK 0
`define RTC_SEL_ALARM 1

`endif

// ===== pkg/rtc_pkg.sv
// Types shared by the real-time clock modules.
// Assumes rtc_consts.svh sits on the include path.
`include "rtc_consts.svh"

package rtc_pkg;
  // Which oscillator feeds the timekeeper
  typedef enum logic {RTC_SRC_MAIN, RTC_SRC_LP} rtc_src_t;
  // Start-up detection of the low-power oscillator
  typedef enum logic [1:0] {RTC_ST_DETECT, RTC_ST_DECIDE, RTC_ST_RUN} rtc_state_t;
endpackage : rtc_pkg

// ===== pkg/rtc_pre_if.sv
// Carrier between the timekeeper core and its prescaler stage.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"

interface rtc_pre_if;
  logic osc_edge;
  logic run;
  logic [`RTC_DIV_W-1:0] period;
  logic tick;
  logic [`RTC_PRE_W-1:0] pre_count;
  logic [`RTC_DIV_W-1:0] div_count;

  // Core side drives the source edge and the period
  modport ctl (output osc_edge, output run, output period,
               input tick, input pre_count, input div_count);
  // Prescaler side turns edges into basic ticks
  modport pre (input osc_edge, input run, input period,
               output tick, output pre_count, output div_count);
endinterface : rtc_pre_if

`default_nettype wire

// ===== core/rtc_prescaler.sv
// Fixed divide-by-64 stage and reloadable 20-bit tick divider.
// Assumes osc_edge is a one-cycle pulse already synchronised to clk.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"

module rtc_prescaler (
  input wire logic clk,
  input wire logic rst,
  rtc_pre_if.pre pre_if
);

  logic div_step;

  // ==========================================================
  // Divide by 64
  // RL6 fixed first stage
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_if.pre_count <= '0;
    end else if (pre_if.run && pre_if.osc_edge) begin
      pre_if.pre_count <= pre_if.pre_count + 6'h01;
    end
  end

  // The divider steps once per wrap of the first stage
  assign div_step = pre_if.run && pre_if.osc_edge && (pre_if.pre_count == `RTC_PRE_LAST);

  // ==========================================================
  // Tick divider
  // RL7 reload from period
  // Counting down to zero keeps a period change from tearing the current tick
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_if.div_count <= `RTC_DIV_RST;
    end else if (div_step) begin
      if (pre_if.div_count == `RTC_DIV_RST) begin
        pre_if.div_count <= pre_if.period;
      end else begin
        pre_if.div_count <= pre_if.div_count - 20'h00001;
      end
    end
  end

  // RL6 tick from divider
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_if.tick <= 1'b0;
    end else begin
      pre_if.tick <= div_step && (pre_if.div_count == `RTC_DIV_RST);
    end
  end

endmodule : rtc_prescaler

`default_nettype wire

// ===== tb/rtc_top_assertions.sv
// Port-level checker for the real-time clock top.
// Assumes it is bound to rtc_top; all checks run on CLK_SYS.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"
module rtc_top_assertions (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic TIME_LOAD,
  input wire logic [`RTC_TIME_W-1:0] TIME_LOAD_VALUE,
  input wire logic ALARM_LOAD,
  input wire logic [`RTC_TIME_W-1:0] ALARM_LOAD_VALUE,
  input wire logic POWERDOWN_MODE,
  input wire logic [1:0] EXTERNAL_IRQ_SOURCE_SELECT,
  input wire logic TICK_INTERRUPT,
  input wire logic ALARM_INTERRUPT,
  input wire logic FAST_EXT_IRQ,
  input wire logic POWERDOWN_WAKE,
  input wire logic MAIN_OSC_ENABLE,
  input wire logic LOW_POWER_OSC_OUTPUT,
  input wire logic [`RTC_TIME_W-1:0] TIME_COUNT,
  input wire logic [`RTC_TIME_W-1:0] ALARM_VALUE
);
  // ==========================================================
  // Single domain, so clock and reset are given once
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);

  chk_time_load: assert property (TIME_LOAD |=> TIME_COUNT == $past(TIME_LOAD_VALUE))
    else $error("time load not taken");
  chk_alarm_load: assert property (ALARM_LOAD |=> ALARM_VALUE == $past(ALARM_LOAD_VALUE))
    else $error("alarm load not taken");
  // A load on the same edge wins, so it is excluded here
  chk_tick_step: assert property (TICK_INTERRUPT && !$past(TIME_LOAD)
    |-> TIME_COUNT == $past(TIME_COUNT) + 1)
    else $error("time count did not step on tick");
  chk_tick_gap: assert property (TICK_INTERRUPT |=> !TICK_INTERRUPT [*8])
    else $error("tick pulses too close");
  // The request is registered once from the compare, so the match shows one edge back
  chk_alarm_cause: assert property (ALARM_INTERRUPT
    |-> $past(TIME_COUNT) == $past(ALARM_VALUE)
    && $past(TIME_COUNT, 2) != $past(ALARM_VALUE, 2))
    else $error("alarm without match start");
  chk_route_fast: assert property ((TICK_INTERRUPT && EXTERNAL_IRQ_SOURCE_SELECT[0])
    || (ALARM_INTERRUPT && EXTERNAL_IRQ_SOURCE_SELECT[1]) |=> FAST_EXT_IRQ)
    else $error("routed request lost");
  chk_fast_cause: assert property (FAST_EXT_IRQ |-> $past(TICK_INTERRUPT
    && EXTERNAL_IRQ_SOURCE_SELECT[0] || ALARM_INTERRUPT && EXTERNAL_IRQ_SOURCE_SELECT[1]))
    else $error("fast request without cause");
  chk_wake_fast: assert property (POWERDOWN_WAKE |-> FAST_EXT_IRQ && $past(POWERDOWN_MODE))
    else $error("wake without fast request in power-down");
  chk_osc_awake: assert property (!POWERDOWN_MODE |=> MAIN_OSC_ENABLE && LOW_POWER_OSC_OUTPUT)
    else $error("oscillator off outside power-down");
endmodule : rtc_top_assertions

bind rtc_top rtc_top_assertions u_chk (.CLK_SYS, .SYS_RST, .TIME_LOAD, .TIME_LOAD_VALUE,
  .ALARM_LOAD, .ALARM_LOAD_VALUE, .POWERDOWN_MODE, .EXTERNAL_IRQ_SOURCE_SELECT,
  .TICK_INTERRUPT, .ALARM_INTERRUPT, .FAST_EXT_IRQ, .POWERDOWN_WAKE, .MAIN_OSC_ENABLE,
  .LOW_POWER_OSC_OUTPUT, .TIME_COUNT, .ALARM_VALUE);
`default_nettype wire

// ===== tb/rtc_osc_model.sv
// Crystal oscillator model feeding one oscillator pin.
// Assumes run follows the block's enable; the pin idles low when stopped.
`timescale 1ns/1ps
`default_nettype none
module rtc_osc_model #(
  parameter int HALF_NS = 16
) (
  input wire logic run,
  output logic osc
);
  // ==========================================================
  // A stopped crystal gives no edges, so the block sees true silence
  initial begin
    osc = 1'b0;
    forever begin
      #(HALF_NS);
      osc = (run === 1'b1) ? ~osc : 1'b0;
    end
  end
endmodule : rtc_osc_model
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the real-time clock top.
// Assumes scaled oscillators: main edge every 8 cycles, low-power every 10.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic lp_on = 1'b0;
  logic tk_en = 1'b1, osc_off = 1'b0, wake_cfg = 1'b0, idle = 1'b0, pd = 1'b0;
  logic tload = 1'b0, aload = 1'b0, tn_en = 1'b0, al_en = 1'b0;
  logic [`RTC_DIV_W-1:0] reload = 20'h00001;
  logic [31:0] tval = 32'h00000000, aval = 32'h00000000, tv;
  logic [15:0] tn_cnt = 16'h0000;
  logic [1:0] sel = 2'h0;
  wire main_osc, lp_osc, t_irq, n_irq, a_irq, f_irq, wake, m_en, lp_en, lp_sel, done;
  wire [31:0] tcnt, aq;
  wire [57:0] ltmr;
  wire [3:0] ev = {n_irq, done, a_irq, t_irq};
  int err_count = 0;
  int n_compared = 0;
  int n;
  int c;

  // ==========================================================
  // Clock, oscillators and the block
  initial begin
    forever #2 clk = ~clk;
  end
  rtc_osc_model #(.HALF_NS(16)) u_main (.run(m_en), .osc(main_osc));
  rtc_osc_model #(.HALF_NS(20)) u_lp (.run(lp_en & lp_on), .osc(lp_osc));
  // Short detection window keeps start-up under a hundred cycles
  rtc_top #(.DETECT_CYCLES(64)) uut (
    .CLK_SYS(clk), .SYS_RST(rst), .MAIN_OSC_INPUT(main_osc), .LOW_POWER_OSC_INPUT(lp_osc),
    .TIMEKEEPER_ENABLE(tk_en), .OSC_OFF_IN_POWERDOWN(osc_off), .POWERDOWN_WAKE_CONFIG(wake_cfg),
    .IDLE_MODE(idle), .POWERDOWN_MODE(pd), .TICK_PERIOD_RELOAD(reload), .TIME_LOAD(tload),
    .TIME_LOAD_VALUE(tval), .ALARM_LOAD(aload), .ALARM_LOAD_VALUE(aval), .TICK_N_ENABLE(tn_en),
    .TICK_N_COUNT(tn_cnt), .ALARM_ENABLE(al_en), .EXTERNAL_IRQ_SOURCE_SELECT(sel),
    .TICK_INTERRUPT(t_irq), .TICK_N_INTERRUPT(n_irq), .ALARM_INTERRUPT(a_irq),
    .FAST_EXT_IRQ(f_irq), .POWERDOWN_WAKE(wake), .MAIN_OSC_ENABLE(m_en),
    .LOW_POWER_OSC_OUTPUT(lp_en), .LP_OSC_SELECTED(lp_sel), .DETECT_DONE(done),
    .TIME_COUNT(tcnt), .ALARM_VALUE(aq), .LONG_TIMER(ltmr)
  );

  // ==========================================================
  // Shared helpers
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic cy(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cy

  // Waits for an event bit, leaving the cycle count in n
  task automatic wt(input int w);
    n = 0;
    do begin
      cy(1);
      n++;
      if (n > 9000) begin
        err_count++;
        $display("[ERR] wait_%0d exp 1 got 0", w);
        print_verdict();
      end
    end while (ev[w] !== 1'b1);
  endtask : wt

  // ==========================================================
  // Scenarios
  task automatic t_tick();
    @(posedge clk);
    idle <= 1'b1;
    wt(0);
    tv = tcnt;
    wt(0);
    chk("tick_period", 64'h400, n);
    chk("time_inc", tv + 32'h1, tcnt);
    @(posedge clk);
    reload <= 20'h00000;
    wt(0);
    wt(0);
    chk("tick_div64", 64'h200, n);
    $display("t_tick done");
  endtask : t_tick

  task automatic t_wrap();
    @(posedge clk);
    tload <= 1'b1;
    tval <= 32'hFFFFFFFF;
    @(posedge clk);
    tload <= 1'b0;
    #1;
    chk("time_load", 64'hFFFFFFFF, tcnt);
    wt(0);
    chk("time_wrap", 64'h0, tcnt);
    $display("t_wrap done");
  endtask : t_wrap

  task automatic t_alarm();
    @(posedge clk);
    aload <= 1'b1;
    aval <= tcnt + 32'h2;
    al_en <= 1'b1;
    sel <= 2'h2;
    @(posedge clk);
    aload <= 1'b0;
    #1;
    chk("alarm_load", aval, aq);
    wt(1);
    chk("alarm_time", aval, tcnt);
    cy(1);
    chk("alarm_route", 64'h1, f_irq);
    $display("t_alarm done");
  endtask : t_alarm

  task automatic t_pd();
    @(posedge clk);
    pd <= 1'b1;
    wake_cfg <= 1'b1;
    sel <= 2'h1;
    cy(2);
    chk("pd_main_on", 64'h1, m_en);
    tv = tcnt;
    wt(0);
    chk("pd_count", tv + 32'h1, tcnt);
    cy(1);
    chk("pd_wake", 64'h1, wake);
    chk("long_time", tcnt, ltmr[57:26]);
    @(posedge clk);
    osc_off <= 1'b1;
    c = 0;
    repeat (1500) begin
      cy(1);
      if (t_irq === 1'b1) c++;
    end
    chk("pd_osc_off", 64'h0, {c, m_en});
    @(posedge clk);
    tk_en <= 1'b0;
    osc_off <= 1'b0;
    cy(2);
    chk("pd_all_off", 64'h0, {m_en, lp_en});
    @(posedge clk);
    pd <= 1'b0;
    tk_en <= 1'b1;
    cy(2);
    chk("awake", 64'h3, {m_en, lp_en});
    $display("t_pd done");
  endtask : t_pd

  task automatic t_tickn();
    @(posedge clk);
    tn_cnt <= 16'h0003;
    tn_en <= 1'b1;
    c = 0;
    repeat (6) begin
      wt(0);
      if (n_irq === 1'b1) c++;
    end
    chk("tick_n", 64'h2, c);
    $display("t_tickn done");
  endtask : t_tickn

  task automatic t_lp();
    @(posedge clk);
    rst <= 1'b1;
    lp_on <= 1'b1;
    tn_en <= 1'b0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wt(2);
    chk("lp_select", 64'h1, lp_sel);
    @(posedge clk);
    pd <= 1'b1;
    cy(2);
    chk("lp_pd_osc", 64'h1, {m_en, lp_en});
    wt(0);
    chk("lp_count", 64'h1, tcnt);
    $display("t_lp done");
  endtask : t_lp

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1;
    chk("rst_time", 64'h0, tcnt);
    chk("rst_alarm", 64'hFFFFFFFF, aq);
    chk("rst_osc", 64'h3, {m_en, lp_en});
    @(posedge clk);
    rst <= 1'b0;
    wt(2);
    chk("main_select", 64'h0, lp_sel);
    t_tick();
    t_wrap();
    t_alarm();
    t_pd();
    t_tickn();
    t_lp();
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
